// *** src/ssl_defines.vh ***
`ifndef SSL_DEFINES_VH
`define SSL_DEFINES_VH

`define SSL_DATA_BITS   18
`define SSL_FRAME_BITS  20
`define SSL_FRAME_LAST  5'h13
`define SSL_RCLK_FALL   5'h09
`define SSL_START_BIT   1'h1
`define SSL_STOP_BIT    1'h0
`define SSL_SYNC_WORD   18'h001FF
`define SSL_ALIGN_HOLD  3'h6
`define SSL_LOCK_GOOD   3'h4
`define SSL_LOSS_BAD    2'h2
`define SSL_PIN_BITS    23

`define SSL_REG_CTRL    4'h0
`define SSL_REG_STATUS  4'h4
`define SSL_REG_LOSSES  4'h8

`define SSL_CTRL_LINE   0
`define SSL_CTRL_LOCAL  1
`define SSL_CTRL_ALIGN  2
`define SSL_CTRL_RESET  3'h0

`define SSL_STAT_LOCKED 0
`define SSL_STAT_SYNC   1
`define SSL_STAT_TXON   2
`define SSL_STAT_RXON   3

`endif

// *** src/ssl_rx_lock.v ***
`timescale 1ns/1ps
`include "ssl_defines.vh"

// Frame hunter and lock detector for the recovered serial bit stream.
module ssl_rx_lock (
  input  wire        clk,        // Core clock, one serial bit per edge.
  input  wire        rstn,       // Asynchronous reset, active low.
  input  wire        bit_in,     // Received serial bit.
  input  wire        bit_ok,     // High when the line carries a real level.
  input  wire        restart,    // Forces a fresh lock acquisition.
  output reg  [17:0] word_ff,    // Last good received word.
  output reg         word_stb_ff, // One-cycle pulse with each valid word.
  output reg         locked_ff   // High while locked to the stream.
);

  localparam ST_HUNT  = 1'b0;
  localparam ST_TRACK = 1'b1;

  reg        state_ff;
  reg        prev_ff;
  reg        err_ff;
  reg  [4:0] cnt_ff;
  reg  [18:0] sh_ff;
  reg  [2:0] good_ff;
  reg  [1:0] bad_ff;
  wire [19:0] frame;
  wire       frame_ok;

  // Pulls the data bits out of a frame, first sent bit becoming bit zero.
  function [17:0] unframe;
    input [19:0] f;
    integer k;
    begin
      unframe = 18'h00000;
      for (k = 0; k < `SSL_DATA_BITS; k = k + 1) begin
        unframe[k] = f[18 - k];
      end
    end
  endfunction

  assign frame    = {sh_ff, bit_in};
  // Start high, stop low and no floating bit inside the frame.
  assign frame_ok = (frame[19] == `SSL_START_BIT) &&
                    (frame[0] == `SSL_STOP_BIT) && !err_ff && bit_ok;

  // Hunts for the stop to start edge, then checks every frame boundary.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= ST_HUNT;
      prev_ff     <= 1'b0;
      err_ff      <= 1'b0;
      cnt_ff      <= 5'h00;
      sh_ff       <= 19'h00000;
      good_ff     <= 3'h0;
      bad_ff      <= 2'h0;
      word_ff     <= 18'h00000;
      word_stb_ff <= 1'b0;
      locked_ff   <= 1'b0;
    end else begin
      prev_ff     <= bit_in & bit_ok;
      word_stb_ff <= 1'b0;
      sh_ff       <= {sh_ff[17:0], bit_in};
      if (restart) begin
        state_ff  <= ST_HUNT;
        locked_ff <= 1'b0;
        good_ff   <= 3'h0;
        bad_ff    <= 2'h0;
      end else begin
        case (state_ff)
          ST_HUNT: begin
            // Only a clean rising edge may start a frame; noise is ignored.
            if (bit_ok && bit_in && !prev_ff) begin
              state_ff <= ST_TRACK;
              cnt_ff   <= 5'h01;
              err_ff   <= 1'b0;
            end
          end
          ST_TRACK: begin
            if (cnt_ff == `SSL_FRAME_LAST) begin
              cnt_ff <= 5'h00;
              err_ff <= 1'b0;
              if (frame_ok) begin
                bad_ff <= 2'h0;
                if (good_ff != `SSL_LOCK_GOOD) begin
                  good_ff <= good_ff + 3'h1;
                end
                if (locked_ff || good_ff == `SSL_LOCK_GOOD - 3'h1) begin
                  locked_ff   <= 1'b1;
                  word_ff     <= unframe(frame);
                  word_stb_ff <= 1'b1;
                end
              end else if (locked_ff) begin
                // Keeps framing through one bad frame, drops on the second.
                if (bad_ff == `SSL_LOSS_BAD - 2'h1) begin
                  locked_ff <= 1'b0;
                  state_ff  <= ST_HUNT;
                  good_ff   <= 3'h0;
                  bad_ff    <= 2'h0;
                end else begin
                  bad_ff <= bad_ff + 2'h1;
                end
              end else begin
                state_ff <= ST_HUNT;
                good_ff  <= 3'h0;
              end
            end else begin
              cnt_ff <= cnt_ff + 5'h01;
              err_ff <= err_ff | !bit_ok;
            end
          end
          default: begin
            state_ff <= ST_HUNT;
          end
        endcase
      end
    end
  end

endmodule

// *** src/ssl_top.v ***
`timescale 1ns/1ps
`include "ssl_defines.vh"

// Serializer and deserializer control core with loopback and lock logic.
// One serial bit moves per clock edge, so a word takes twenty edges.
module ssl_top (
  input  wire        clk,                    // Core clock, 25 MHz.
  input  wire        rstn,                   // Asynchronous reset, low.
  input  wire [3:0]  avs_address,            // Avalon byte address.
  input  wire        avs_read,               // Avalon read request.
  input  wire        avs_write,              // Avalon write request.
  input  wire [31:0] avs_writedata,          // Avalon write data.
  input  wire [3:0]  avs_byteenable,         // Avalon byte lanes.
  output reg  [31:0] avs_readdata,           // Avalon read data.
  output reg         avs_waitrequest,        // Avalon stall, high idle.
  input  wire        receive_output_enable,  // Low floats receive outputs.
  input  wire        receiver_powerdown_n,   // Low puts receiver down.
  input  wire        serial_driver_enable,   // Low floats serial driver.
  input  wire [17:0] parallel_tx_word,       // Word to be serialized.
  input  wire        serial_in_p,            // Serial input, true leg.
  input  wire        serial_in_n,            // Serial input, inverted leg.
  output reg         serial_out_p,           // Serial output, true leg.
  output reg         serial_out_n,           // Serial output, inverted leg.
  output reg         serial_out_oe,          // Serial driver enable.
  output reg  [17:0] parallel_rx_word,       // Received word.
  output reg         parallel_rx_word_oe,    // Received word enable.
  output reg         recovered_clock,        // Clock with received word.
  output reg         recovered_clock_oe,     // Recovered clock enable.
  output reg         sync_achieved_n         // Low while locked.
);

  // Pin synchroniser stages and the agreed level of each pin.
  reg  [22:0] pin_s1_ff;
  reg  [22:0] pin_s2_ff;
  reg  [22:0] pin_s3_ff;
  reg  [22:0] pin_ff;
  wire [22:0] pin_raw;
  wire        ren_f;
  wire        pwdn_n_f;
  wire        den_f;
  wire        sin_p_f;
  wire        sin_n_f;
  wire [17:0] txw_f;

  // Software control and mode tracking.
  reg  [2:0]  ctrl_ff;
  reg  [1:0]  mode_ff;
  reg         pwdn_q_ff;
  wire        line_mode;
  wire        local_mode;
  wire [1:0]  mode_now;
  wire        restart;

  // Transmit frame state.
  reg  [4:0]  tx_cnt_ff;
  reg  [19:0] tx_sh_ff;
  reg  [2:0]  align_cnt_ff;
  reg         sync_send_ff;
  reg  [17:0] lb_word_ff;
  reg  [2:0]  nxt_align_cnt;
  reg  [17:0] tx_src;
  wire [17:0] tx_rev;
  wire        tx_bit;

  // Receive side.
  wire        rx_bit;
  wire        rx_ok;
  wire [17:0] rx_word;
  wire        rx_stb;
  wire        rx_locked;
  reg         lock_q_ff;
  reg  [7:0]  loss_cnt_ff;
  reg  [4:0]  rclk_cnt_ff;
  wire        rx_drive;

  // Bus slave.
  wire        bus_req;
  reg  [31:0] rd_mux;

  assign pin_raw = {receive_output_enable, receiver_powerdown_n,
                    serial_driver_enable, serial_in_p, serial_in_n,
                    parallel_tx_word};

  // Every pin passes three flops; a change counts once stages two and
  // three agree, so a single late sample cannot reach the logic.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_ff <= 23'h000000;
      pin_s2_ff <= 23'h000000;
      pin_s3_ff <= 23'h000000;
      pin_ff    <= 23'h000000;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ff    <= (pin_s2_ff & pin_s3_ff) |
                   (pin_ff & (pin_s2_ff ^ pin_s3_ff));
    end
  end

  assign ren_f    = pin_ff[22];
  assign pwdn_n_f = pin_ff[21];
  assign den_f    = pin_ff[20];
  // Serial legs change every bit, so they skip the agreement filter and
  // take the third stage; filtering would erase single-bit pulses.
  assign sin_p_f  = pin_s3_ff[19];
  assign sin_n_f  = pin_s3_ff[18];
  assign txw_f    = pin_ff[17:0];

  // Local loopback outranks line loopback if software sets both.
  assign local_mode = ctrl_ff[`SSL_CTRL_LOCAL];
  assign line_mode  = ctrl_ff[`SSL_CTRL_LINE] & ~local_mode;
  assign mode_now   = {local_mode, line_mode};

  // A mode change or a powered-down receiver restarts acquisition.
  assign restart = (mode_now != mode_ff) | ~pwdn_n_f;

  // The sampled mode lags the control register by one edge.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_ff   <= 2'h0;
      pwdn_q_ff <= 1'b0;
    end else begin
      mode_ff   <= mode_now;
      pwdn_q_ff <= pwdn_n_f;
    end
  end

  // Chooses the word for the next frame: sync pattern, looped word or
  // the parallel input, and counts word cycles of the align request.
  always @* begin
    nxt_align_cnt = 3'h0;
    if (ctrl_ff[`SSL_CTRL_ALIGN]) begin
      if (align_cnt_ff == `SSL_ALIGN_HOLD) begin
        nxt_align_cnt = `SSL_ALIGN_HOLD;
      end else begin
        nxt_align_cnt = align_cnt_ff + 3'h1;
      end
    end
    if (nxt_align_cnt == `SSL_ALIGN_HOLD) begin
      tx_src = `SSL_SYNC_WORD;
    end else if (line_mode) begin
      tx_src = lb_word_ff;
    end else begin
      tx_src = txw_f;
    end
  end

  // Places data bit zero first on the line after the start bit.
  genvar gi;
  generate
    for (gi = 0; gi < `SSL_DATA_BITS; gi = gi + 1) begin : g_rev
      assign tx_rev[17 - gi] = tx_src[gi];
    end
  endgenerate

  assign tx_bit = tx_sh_ff[19];

  // Serializer runs regardless of the driver enable, so re-enabling
  // the driver simply shows the stream that was running all along.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_cnt_ff    <= 5'h00;
      tx_sh_ff     <= 20'h00000;
      align_cnt_ff <= 3'h0;
      sync_send_ff <= 1'b0;
    end else begin
      if (tx_cnt_ff == `SSL_FRAME_LAST) begin
        tx_cnt_ff    <= 5'h00;
        // Each frame gets fresh start and stop clock bits.
        tx_sh_ff     <= {`SSL_START_BIT, tx_rev, `SSL_STOP_BIT};
        align_cnt_ff <= nxt_align_cnt;
        sync_send_ff <= (nxt_align_cnt == `SSL_ALIGN_HOLD);
      end else begin
        tx_cnt_ff <= tx_cnt_ff + 5'h01;
        tx_sh_ff  <= {tx_sh_ff[18:0], 1'b0};
      end
    end
  end

  // Serial driver: enable from the pin, forced off in local loopback.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serial_out_p  <= 1'b0;
      serial_out_n  <= 1'b1;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_p  <= tx_bit;
      serial_out_n  <= ~tx_bit;
      serial_out_oe <= den_f & ~local_mode;
    end
  end

  // Local loopback feeds the deserializer from the serializer; a line
  // with both legs at one level is treated as floating.
  assign rx_bit = local_mode ? tx_bit : sin_p_f;
  assign rx_ok  = local_mode | (sin_p_f ^ sin_n_f);

  ssl_rx_lock u_rx_lock (
    .clk         (clk),
    .rstn        (rstn),
    .bit_in      (rx_bit),
    .bit_ok      (rx_ok),
    .restart     (restart),
    .word_ff     (rx_word),
    .word_stb_ff (rx_stb),
    .locked_ff   (rx_locked)
  );

  // Line loopback retransmits the newest received word in new frames.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lb_word_ff <= 18'h00000;
    end else if (rx_stb) begin
      lb_word_ff <= rx_word;
    end
  end

  // Receive outputs drive only when enabled, powered and locked.
  assign rx_drive = ren_f & pwdn_n_f & rx_locked;

  // Received word, recovered clock and lock flag move together, so the
  // word is valid exactly while sync_achieved_n is low.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      parallel_rx_word    <= 18'h00000;
      parallel_rx_word_oe <= 1'b0;
      recovered_clock     <= 1'b0;
      recovered_clock_oe  <= 1'b0;
      sync_achieved_n     <= 1'b1;
      rclk_cnt_ff         <= 5'h00;
    end else begin
      if (rx_stb) begin
        parallel_rx_word <= rx_word;
        recovered_clock  <= 1'b1;
        rclk_cnt_ff      <= 5'h00;
      end else begin
        if (rclk_cnt_ff == `SSL_RCLK_FALL) begin
          recovered_clock <= 1'b0;
        end
        if (rclk_cnt_ff != `SSL_FRAME_LAST) begin
          rclk_cnt_ff <= rclk_cnt_ff + 5'h01;
        end
      end
      // The lock is kept while receive_output_enable floats the outputs, so enabling resumes.
      parallel_rx_word_oe <= rx_drive;
      recovered_clock_oe  <= rx_drive;
      sync_achieved_n     <= ~(rx_locked & pwdn_n_f);
    end
  end

  // Counts lock losses for software, saturating at the top.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_q_ff   <= 1'b0;
      loss_cnt_ff <= 8'h00;
    end else begin
      lock_q_ff <= rx_locked;
      if (lock_q_ff && !rx_locked && loss_cnt_ff != 8'hFF) begin
        loss_cnt_ff <= loss_cnt_ff + 8'h01;
      end
    end
  end

  assign bus_req = avs_read | avs_write;

  // Read data selection; unmapped addresses read as zero.
  always @* begin
    rd_mux = 32'h00000000;
    case (avs_address)
      `SSL_REG_CTRL: begin
        rd_mux[2:0] = ctrl_ff;
      end
      `SSL_REG_STATUS: begin
        rd_mux[`SSL_STAT_LOCKED] = rx_locked;
        rd_mux[`SSL_STAT_SYNC]   = sync_send_ff;
        rd_mux[`SSL_STAT_TXON]   = serial_out_oe;
        rd_mux[`SSL_STAT_RXON]   = parallel_rx_word_oe & pwdn_q_ff;
      end
      `SSL_REG_LOSSES: begin
        rd_mux[7:0] = loss_cnt_ff;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // Avalon slave: waitrequest drops for one cycle, one edge after the
  // request appears; the write lands at the edge that sees it low.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      ctrl_ff         <= `SSL_CTRL_RESET;
    end else begin
      if (bus_req && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        if (avs_read) begin
          avs_readdata <= rd_mux;
        end
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (avs_write && !avs_waitrequest && avs_byteenable[0] &&
          avs_address == `SSL_REG_CTRL) begin
        ctrl_ff <= avs_writedata[2:0];
      end
    end
  end

endmodule

// *** tb/ssl_peer_model.sv ***
`timescale 1ns/1ps
`include "ssl_defines.vh"

// Far serializer: sends framed words back to back, one bit per edge.
module ssl_peer_model (
  input  wire        clk,      // Core clock.
  input  wire        rstn,     // Reset, active low.
  input  wire        line_on,  // Low leaves the line floating.
  input  wire        bad_stop, // High breaks the stop bit of a frame.
  input  wire        sync_req, // High sends sync words instead of data.
  input  wire [17:0] word,     // Word to send.
  output wire        ser_p,    // Line, true leg.
  output wire        ser_n     // Line, inverted leg.
);
  reg [4:0]  cnt_ff;
  reg [19:0] sh_ff;
  reg        tog_ff;
  reg        on_ff;

  // Frame is start one, data bit 0 first, then stop zero.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 5'h00;
      sh_ff  <= 20'h00000;
      tog_ff <= 1'h0;
      on_ff  <= 1'h0;
    end else begin
      tog_ff <= ~tog_ff;
      cnt_ff <= (cnt_ff == `SSL_FRAME_LAST) ? 5'h00 : cnt_ff + 5'h01;
      if (cnt_ff == `SSL_FRAME_LAST) begin
        on_ff <= line_on;
        sh_ff <= {bad_stop, sync_req ? `SSL_SYNC_WORD : word,
                  `SSL_START_BIT};
      end else begin
        sh_ff <= sh_ff >> 1;
      end
    end
  end

  // A released line shows equal legs that change every cycle; the line
  // is connected or cut only at a frame boundary.
  assign ser_p = on_ff ? sh_ff[0] : tog_ff;
  assign ser_n = on_ff ? ~sh_ff[0] : tog_ff;
endmodule

// *** tb/ssl_top_checker.sv ***
`timescale 1ns/1ps
`include "ssl_defines.vh"

// Watches the core's pins for tri-state, lock and bus behaviour.
module ssl_top_checker (
  input wire        clk,                   // Core clock.
  input wire        rstn,                  // Reset, active low.
  input wire [3:0]  avs_address,           // Bus address.
  input wire        avs_read,              // Bus read.
  input wire        avs_write,             // Bus write.
  input wire [31:0] avs_writedata,         // Bus write data.
  input wire [3:0]  avs_byteenable,        // Bus lanes.
  input wire        avs_waitrequest,       // Bus stall.
  input wire        receive_output_enable, // Receive output enable.
  input wire        receiver_powerdown_n,  // Receiver powerdown.
  input wire        serial_driver_enable,  // Serial driver enable.
  input wire        serial_out_p,          // Serial out, true leg.
  input wire        serial_out_n,          // Serial out, inverted leg.
  input wire        serial_out_oe,         // Serial driver on.
  input wire [17:0] parallel_rx_word,      // Received word.
  input wire        parallel_rx_word_oe,   // Received word on.
  input wire        recovered_clock,       // Recovered clock.
  input wire        recovered_clock_oe,    // Recovered clock on.
  input wire        sync_achieved_n        // Low while locked.
);
  reg [1:0] mode_ff;
  reg       chg_ff;
  wire      wr_ok;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Tracks the loopback mode from accepted control writes.
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0] &&
                 avs_address == `SSL_REG_CTRL;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_ff <= 2'h0;
      chg_ff  <= 1'h0;
    end else begin
      chg_ff <= wr_ok && avs_writedata[1:0] != mode_ff;
      if (wr_ok) begin
        mode_ff <= avs_writedata[1:0];
      end
    end
  end

  sequence s_request;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_one_wait;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_one_wait: assert property (s_request |=> s_one_wait)
    else $error("bus answer not after exactly one wait");
  a_rx_float: assert property (
    !receive_output_enable [*6] |-> !parallel_rx_word_oe &&
    !recovered_clock_oe) else $error("receive outputs still driven");
  a_oe_pair: assert property (
    parallel_rx_word_oe == recovered_clock_oe)
    else $error("word and clock enables differ");
  a_valid_locked: assert property (
    parallel_rx_word_oe |-> !sync_achieved_n)
    else $error("outputs driven while unlocked");
  a_drv_float: assert property (
    !serial_driver_enable [*6] |-> !serial_out_oe)
    else $error("serial driver on while disabled");
  a_local_off: assert property (
    mode_ff[1] [*4] |-> !serial_out_oe)
    else $error("serial driver on in local loopback");
  a_mode_relock: assert property (
    chg_ff |-> ##[0:8] sync_achieved_n)
    else $error("no lock drop after mode change");
  a_legs_differ: assert property (
    serial_out_n != serial_out_p) else $error("serial legs equal");
  a_pwdn_unlock: assert property (
    !receiver_powerdown_n [*6] |-> sync_achieved_n)
    else $error("lock shown while powered down");
  a_word_hold: assert property (
    $rose(recovered_clock) |=> $stable(parallel_rx_word) [*8])
    else $error("word changed while recovered clock high");
endmodule

bind ssl_top ssl_top_checker ssl_top_checker_inst (
  .clk(clk), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest),
  .receive_output_enable(receive_output_enable),
  .receiver_powerdown_n(receiver_powerdown_n),
  .serial_driver_enable(serial_driver_enable),
  .serial_out_p(serial_out_p), .serial_out_n(serial_out_n),
  .serial_out_oe(serial_out_oe), .parallel_rx_word(parallel_rx_word),
  .parallel_rx_word_oe(parallel_rx_word_oe),
  .recovered_clock(recovered_clock),
  .recovered_clock_oe(recovered_clock_oe),
  .sync_achieved_n(sync_achieved_n));

// *** tb/tb_ssl_top.sv ***
`timescale 1ns/1ps
`include "ssl_defines.vh"

// Self-checking bench for the link control core.
module tb_ssl_top;
  // Words whose frames hold a single rising edge, so framing is unique.
  localparam [17:0] WORD_A = 18'h0007F;
  localparam [17:0] WORD_B = 18'h00FFF;
  logic        clk, rstn, avs_read, avs_write;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, rd;
  logic        receive_output_enable, receiver_powerdown_n;
  logic        serial_driver_enable, line_on, bad_stop, sync_req, held;
  logic [17:0] parallel_tx_word;
  wire  [31:0] avs_readdata;
  wire  [17:0] parallel_rx_word;
  wire         avs_waitrequest, serial_in_p, serial_in_n, serial_out_p;
  wire         serial_out_n, serial_out_oe, parallel_rx_word_oe;
  wire         recovered_clock, recovered_clock_oe, sync_achieved_n;
  integer      miscompares = 0;
  integer      compares = 0;
  integer      cyc = 0;

  ssl_top ssl_top_inst (
    .clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .receive_output_enable(receive_output_enable),
    .receiver_powerdown_n(receiver_powerdown_n),
    .serial_driver_enable(serial_driver_enable),
    .parallel_tx_word(parallel_tx_word), .serial_in_p(serial_in_p),
    .serial_in_n(serial_in_n), .serial_out_p(serial_out_p),
    .serial_out_n(serial_out_n), .serial_out_oe(serial_out_oe),
    .parallel_rx_word(parallel_rx_word),
    .parallel_rx_word_oe(parallel_rx_word_oe),
    .recovered_clock(recovered_clock),
    .recovered_clock_oe(recovered_clock_oe),
    .sync_achieved_n(sync_achieved_n));

  ssl_peer_model ssl_peer_model_inst (
    .clk(clk), .rstn(rstn), .line_on(line_on), .bad_stop(bad_stop),
    .sync_req(sync_req), .word(WORD_A), .ser_p(serial_in_p),
    .ser_n(serial_in_n));

  // Core clock at 25 MHz, shared by both link ends and always running.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Cuts a hung run short.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      report_and_stop;
    end
  end

  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // One bus access; holds the request until wait is sampled low.
  task bus(input wr, input [3:0] a, input [31:0] wd, input [3:0] be);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      avs_address    <= a;
      avs_writedata  <= wd;
      avs_byteenable <= be;
      avs_write      <= wr;
      avs_read       <= ~wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 40) begin
        n = n + 1;
        @(posedge clk);
      end
      if (n == 40)
        miscompares = miscompares + 1;
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
    end
  endtask

  task wait_sync(input v);
    integer n;
    begin
      n = 0;
      while (sync_achieved_n !== v && n < 400) begin
        @(posedge clk);
        n = n + 1;
      end
      chk("sync", sync_achieved_n, v);
    end
  endtask

  task report_and_stop;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // Main sequence.
  initial begin
    rstn = 1'b0;
    {avs_read, avs_write, avs_address, avs_byteenable} = 10'h000;
    avs_writedata = 32'h00000000;
    {receive_output_enable, receiver_powerdown_n} = 2'h3;
    serial_driver_enable = 1'b1;
    parallel_tx_word = 18'h00000;
    {line_on, bad_stop, sync_req} = 3'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    chk("rx_oe", parallel_rx_word_oe, 1'b0);
    bus(1'b0, 4'hC, 32'h00000000, 4'hF);
    chk("unmapped", rd, 32'h00000000);
    line_on <= 1'b1;
    wait_sync(1'b0);
    repeat (25) @(posedge clk);
    chk("word", parallel_rx_word, WORD_A);
    chk("rx_oe", parallel_rx_word_oe, 1'b1);
    bus(1'b0, `SSL_REG_STATUS, 32'h00000000, 4'hF);
    chk("status", rd, 32'h0000000D);
    receive_output_enable <= 1'b0;
    serial_driver_enable  <= 1'b0;
    repeat (10) @(posedge clk);
    chk("rclk_oe", recovered_clock_oe, 1'b0);
    chk("tx_oe", serial_out_oe, 1'b0);
    chk("sync", sync_achieved_n, 1'b0);
    receive_output_enable <= 1'b1;
    serial_driver_enable  <= 1'b1;
    repeat (10) @(posedge clk);
    chk("rx_oe", parallel_rx_word_oe, 1'b1);
    chk("word", parallel_rx_word, WORD_A);
    chk("tx_oe", serial_out_oe, 1'b1);
    receiver_powerdown_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk("sync", sync_achieved_n, 1'b1);
    receiver_powerdown_n <= 1'b1;
    wait_sync(1'b0);
    // Control write without lane 0 is ignored.
    bus(1'b1, `SSL_REG_CTRL, 32'h00000002, 4'h0);
    bus(1'b0, `SSL_REG_CTRL, 32'h00000000, 4'hF);
    chk("ctrl", rd, 32'h00000000);
    parallel_tx_word <= WORD_B;
    bus(1'b1, `SSL_REG_CTRL, 32'h00000002, 4'h1);
    wait_sync(1'b1);
    repeat (8) @(posedge clk);
    chk("tx_oe", serial_out_oe, 1'b0);
    wait_sync(1'b0);
    repeat (25) @(posedge clk);
    chk("word", parallel_rx_word, WORD_B);
    bus(1'b1, `SSL_REG_CTRL, 32'h00000006, 4'h1);
    repeat (200) @(posedge clk);
    bus(1'b0, `SSL_REG_STATUS, 32'h00000000, 4'hF);
    chk("align", rd[1], 1'b1);
    chk("word", parallel_rx_word, `SSL_SYNC_WORD);
    bus(1'b1, `SSL_REG_CTRL, 32'h00000001, 4'h1);
    wait_sync(1'b1);
    wait_sync(1'b0);
    repeat (25) @(posedge clk);
    chk("word", parallel_rx_word, WORD_A);
    chk("tx_oe", serial_out_oe, 1'b1);
    bus(1'b1, `SSL_REG_CTRL, 32'h00000000, 4'h1);
    wait_sync(1'b1);
    wait_sync(1'b0);
    // One bad frame keeps lock, two in a row lose it.
    bad_stop <= 1'b1;
    repeat (20) @(posedge clk);
    bad_stop <= 1'b0;
    held = 1'b1;
    repeat (80) begin
      @(posedge clk);
      if (sync_achieved_n !== 1'b0)
        held = 1'b0;
    end
    chk("held", held, 1'b1);
    bad_stop <= 1'b1;
    repeat (40) @(posedge clk);
    bad_stop <= 1'b0;
    sync_req <= 1'b1;
    wait_sync(1'b1);
    wait_sync(1'b0);
    repeat (25) @(posedge clk);
    chk("word", parallel_rx_word, `SSL_SYNC_WORD);
    sync_req <= 1'b0;
    line_on  <= 1'b0;
    wait_sync(1'b1);
    repeat (60) @(posedge clk);
    chk("rx_oe", parallel_rx_word_oe, 1'b0);
    chk("sync", sync_achieved_n, 1'b1);
    report_and_stop;
  end
endmodule
